// >>> design/fifb_pkg.sv
// Package with offsets, bit positions and reset values of the fault flag banks
package fifb_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] FIFB_OFF_BUCK_STAT = 8'h08; // Buck latched flags
   localparam logic [7:0] FIFB_OFF_BUCK_MASK = 8'h09; // Buck mask bits
   localparam logic [7:0] FIFB_OFF_BUCK_SENSE = 8'h0A; // Buck live state
   localparam logic [7:0] FIFB_OFF_MISC_STAT = 8'h0E; // Boost, supply, fuse flags
   localparam logic [7:0] FIFB_OFF_MISC_MASK = 8'h0F; // Boost, supply, fuse masks
   localparam logic [7:0] FIFB_OFF_MISC_SENSE = 8'h10; // Boost, supply, fuse live
   localparam logic [7:0] FIFB_OFF_LIN_STAT = 8'h11; // Linear latched flags
   localparam logic [7:0] FIFB_OFF_LIN_MASK = 8'h12; // Linear mask bits
   localparam logic [7:0] FIFB_OFF_LIN_SENSE = 8'h13; // Linear live state

   // ----------------------------------------
   // Bit positions
   // ----------------------------------------
   localparam int FIFB_FLG_BUCK1A = 0; // Flag and mask, buck 1A
   localparam int FIFB_FLG_BUCK1B = 1; // Flag and mask, buck 1B
   localparam int FIFB_FLG_BUCK2 = 3; // Flag and mask, buck 2
   localparam int FIFB_FLG_BUCK3 = 4; // Flag and mask, buck 3
   localparam int FIFB_SNS_BUCK1A = 0; // Sense, buck 1A
   localparam int FIFB_SNS_BUCK1B = 2; // Sense, buck 1B sits one bit higher
   localparam int FIFB_SNS_BUCK2 = 3; // Sense, buck 2
   localparam int FIFB_SNS_BUCK3 = 4; // Sense, buck 3
   localparam int FIFB_BIT_BOOST = 0; // Boost overcurrent
   localparam int FIFB_BIT_SUPPLY_OV = 2; // Front supply overvoltage
   localparam int FIFB_BIT_BLOW = 6; // Fuse auto-blow
   localparam int FIFB_BIT_FUSE_ERR = 7; // Fuse memory error

   // ----------------------------------------
   // Implemented bits and reset values
   // ----------------------------------------
   localparam logic [7:0] FIFB_BUCK_FLAG_BITS = 8'h1B; // Flags 0,1,3,4
   localparam logic [7:0] FIFB_BUCK_MASK_BITS = 8'h7F; // Mask bits 0 to 6
   localparam logic [7:0] FIFB_BUCK_MASK_RST = 8'h7F; // Bit 7 reads 0
   localparam logic [7:0] FIFB_MISC_FLAG_BITS = 8'hC5; // Flags 0,2,6,7
   localparam logic [7:0] FIFB_MISC_MASK_BITS = 8'hC5; // Masks 0,2,6,7
   localparam logic [7:0] FIFB_MISC_MASK_RST = 8'hC5; // Used masks reset to 1
   localparam logic [7:0] FIFB_LIN_FLAG_BITS = 8'h3F; // Flags 0 to 5
   localparam logic [7:0] FIFB_LIN_MASK_BITS = 8'h3F; // Masks 0 to 5
   localparam logic [7:0] FIFB_LIN_MASK_RST = 8'h3F; // Bits 7:6 read 0
   localparam logic [7:0] FIFB_ZERO = 8'h00; // Unmapped read value

   // ----------------------------------------
   // Start-up phase
   // ----------------------------------------
   typedef enum logic [0:0] {
      FIFB_BOOT = 1'b0, // First cycle after reset release, strap sampled
      FIFB_RUN = 1'b1 // Normal operation
   } fifb_phase_e;

endpackage

// >>> design/fifb_bank_if.sv
// Interface between the register front end and one flag bank
interface fifb_bank_if;
   logic [7:0] wdata; // Write data from the register port
   logic wr_stat; // Write strobe to the status register
   logic wr_mask; // Write strobe to the mask register
   logic [7:0] evt; // One-cycle fault events, already placed
   logic [7:0] flag; // Latched flags
   logic [7:0] mask; // Mask bits
   logic pend; // Any unmasked flag set

   modport ctrl (output wdata, output wr_stat, output wr_mask, output evt,
                 input flag, input mask, input pend);
   modport bank (input wdata, input wr_stat, input wr_mask, input evt,
                 output flag, output mask, output pend);
endinterface

// >>> design/fifb_flag_bank.sv
// One bank of latched flags with write-one-to-clear and a mask register
module fifb_flag_bank
   import fifb_pkg::*;
#(
   parameter logic [7:0] FLAG_BITS = 8'hFF, // Flags that exist
   parameter logic [7:0] MASK_BITS = 8'hFF, // Mask bits that are writable
   parameter logic [7:0] MASK_RST = 8'hFF // Mask reset value
) (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Asynchronous reset, active high
   fifb_bank_if.bank bif // Bank signals
);

   logic [7:0] flag_q; // Latched flags
   logic [7:0] flag_d; // Next latched flags
   logic [7:0] mask_q; // Mask register
   logic [7:0] mask_d; // Next mask register
   logic [7:0] clr_w; // Bits cleared by a write of 1
   logic [7:0] set_w; // Bits set by an event this cycle

   // ----------------------------------------
   // Next-state decode
   // ----------------------------------------
   // Only ones in the write data clear; zeros leave the flag alone
   assign clr_w = bif.wr_stat ? bif.wdata : FIFB_ZERO;
   assign set_w = bif.evt & FLAG_BITS;
   // Set is OR-ed after the clear so a same-cycle event is never lost
   assign flag_d = ((flag_q & ~clr_w) | set_w) & FLAG_BITS;
   // Unused mask bits stay at their reset value of 0
   assign mask_d = bif.wr_mask ? (bif.wdata & MASK_BITS) : mask_q;
   assign bif.flag = flag_q;
   assign bif.mask = mask_q;
   // A flag reaches the interrupt only where its mask bit is 0
   assign bif.pend = |(flag_q & ~mask_q);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Flags clear to 0, masks come up masked
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flag_q <= FIFB_ZERO;
         mask_q <= MASK_RST;
      end else begin
         flag_q <= flag_d;
         mask_q <= mask_d;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_set_beats_clear: assert property (
      @(posedge clk_sys) disable iff (reset)
      (set_w != FIFB_ZERO) |=> ((flag_q & $past(set_w)) == $past(set_w)))
      else $error("Fault event lost in flag bank");

   a_zero_write_keeps: assert property (
      @(posedge clk_sys) disable iff (reset)
      bif.wr_stat |=> ((flag_q & $past(flag_q) & ~$past(bif.wdata))
                       == ($past(flag_q) & ~$past(bif.wdata))))
      else $error("Flag cleared without a write of 1");

   a_one_write_clears: assert property (
      @(posedge clk_sys) disable iff (reset)
      (bif.wr_stat && set_w == FIFB_ZERO) |=> ((flag_q & $past(bif.wdata)) == FIFB_ZERO))
      else $error("Write of 1 did not clear flag");

   a_flag_holds: assert property (
      @(posedge clk_sys) disable iff (reset)
      (!bif.wr_stat && flag_q != FIFB_ZERO) |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
      else $error("Latched flag dropped by itself");

   a_unused_zero: assert property (
      @(posedge clk_sys) disable iff (reset)
      ((flag_q & ~FLAG_BITS) == FIFB_ZERO) && ((mask_q & ~MASK_BITS) == FIFB_ZERO))
      else $error("Unused bit reads nonzero");

endmodule

// >>> design/fifb_fault_irq.sv
// Top of the fault interrupt flag banks: register port, edge detect, irq out
module fifb_fault_irq
   import fifb_pkg::*;
(
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic reset, // Asynchronous reset, active high
   input wire logic [7:0] reg_addr, // Register address
   input wire logic reg_wr_en, // Write strobe, one cycle
   input wire logic reg_rd_en, // Read strobe, one cycle
   input wire logic [7:0] reg_wdata, // Write data
   output logic [7:0] reg_rdata, // Read data, valid the cycle after a read
   input wire logic [3:0] buck_oc_live, // Buck 3,2,1B,1A overcurrent
   input wire logic boost_oc_live, // Boost overcurrent
   input wire logic supply_ov_live, // Front supply overvoltage
   input wire logic front_supply_grounded, // Strap: powered by main input path
   input wire logic auto_blow_running, // Fuse auto-blow sequence running
   input wire logic fuse_error_live, // Fuse memory error detected
   input wire logic [5:0] linear_oc_live, // ldo4,ldo3,rail33,card,ldo2,ldo1
   output logic irq_out_n // Shared interrupt, active low
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Place one bit at a position in an otherwise empty byte
   function automatic logic [7:0] put_bit(input logic b, input int pos);
      put_bit = 8'(b) << pos;
   endfunction

   // Low-to-high transition of a live condition
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   fifb_bank_if bif_buck (); // Buck bank
   fifb_bank_if bif_misc (); // Boost, supply, fuse bank
   fifb_bank_if bif_lin (); // Linear bank

   logic [3:0] buck_prev_q; // Previous buck state
   logic boost_prev_q; // Previous boost state
   logic supply_prev_q; // Previous overvoltage state
   logic blow_prev_q; // Previous auto-blow running
   logic fuse_prev_q; // Previous fuse error
   logic [5:0] lin_prev_q; // Previous linear state
   fifb_phase_e phase_q; // Start-up phase
   fifb_phase_e phase_d; // Next phase
   logic [7:0] rdata_q; // Read data register
   logic [7:0] rdata_d; // Next read data
   logic irq_n_q; // Interrupt output register
   logic [7:0] buck_sense_w; // Buck sense byte
   logic [7:0] misc_sense_w; // Misc sense byte
   logic [7:0] lin_sense_w; // Linear sense byte
   logic [7:0] buck_evt_w; // Buck events
   logic [7:0] misc_evt_w; // Misc events
   logic [7:0] lin_evt_w; // Linear events
   logic strap_set_w; // Start-up set of the overvoltage flag
   logic [7:0] rd_mux_w; // Selected read data
   logic any_pend_w; // Any bank pending

   // ----------------------------------------
   // Sense bytes, straight from the live inputs
   // ----------------------------------------
   // No storage here, so a write can never disturb them
   assign buck_sense_w = put_bit(buck_oc_live[0], FIFB_SNS_BUCK1A)
                       | put_bit(buck_oc_live[1], FIFB_SNS_BUCK1B)
                       | put_bit(buck_oc_live[2], FIFB_SNS_BUCK2)
                       | put_bit(buck_oc_live[3], FIFB_SNS_BUCK3);
   assign misc_sense_w = put_bit(boost_oc_live, FIFB_BIT_BOOST)
                       | put_bit(supply_ov_live, FIFB_BIT_SUPPLY_OV)
                       | put_bit(auto_blow_running, FIFB_BIT_BLOW)
                       | put_bit(fuse_error_live, FIFB_BIT_FUSE_ERR);
   assign lin_sense_w = {2'h0, linear_oc_live};

   // ----------------------------------------
   // Events
   // ----------------------------------------
   // Overcurrent and errors trigger on the rising edge of the condition
   assign buck_evt_w = put_bit(rise(buck_oc_live[0], buck_prev_q[0]), FIFB_FLG_BUCK1A)
                     | put_bit(rise(buck_oc_live[1], buck_prev_q[1]), FIFB_FLG_BUCK1B)
                     | put_bit(rise(buck_oc_live[2], buck_prev_q[2]), FIFB_FLG_BUCK2)
                     | put_bit(rise(buck_oc_live[3], buck_prev_q[3]), FIFB_FLG_BUCK3);
   // Strap is taken once, in the first clocked cycle after reset release
   assign strap_set_w = (phase_q == FIFB_BOOT) & front_supply_grounded;
   // Auto-blow done is the falling edge of the running indication
   assign misc_evt_w = put_bit(rise(boost_oc_live, boost_prev_q), FIFB_BIT_BOOST)
                     | put_bit(rise(supply_ov_live, supply_prev_q) | strap_set_w,
                               FIFB_BIT_SUPPLY_OV)
                     | put_bit(rise(blow_prev_q, auto_blow_running), FIFB_BIT_BLOW)
                     | put_bit(rise(fuse_error_live, fuse_prev_q), FIFB_BIT_FUSE_ERR);
   assign lin_evt_w = {2'h0, linear_oc_live & ~lin_prev_q};

   // ----------------------------------------
   // Register port decode
   // ----------------------------------------
   assign bif_buck.wdata = reg_wdata;
   assign bif_buck.wr_stat = reg_wr_en && (reg_addr == FIFB_OFF_BUCK_STAT);
   assign bif_buck.wr_mask = reg_wr_en && (reg_addr == FIFB_OFF_BUCK_MASK);
   assign bif_buck.evt = buck_evt_w;
   assign bif_misc.wdata = reg_wdata;
   assign bif_misc.wr_stat = reg_wr_en && (reg_addr == FIFB_OFF_MISC_STAT);
   assign bif_misc.wr_mask = reg_wr_en && (reg_addr == FIFB_OFF_MISC_MASK);
   assign bif_misc.evt = misc_evt_w;
   assign bif_lin.wdata = reg_wdata;
   assign bif_lin.wr_stat = reg_wr_en && (reg_addr == FIFB_OFF_LIN_STAT);
   assign bif_lin.wr_mask = reg_wr_en && (reg_addr == FIFB_OFF_LIN_MASK);
   assign bif_lin.evt = lin_evt_w;

   // Unmapped addresses read as 0
   assign rd_mux_w = (reg_addr == FIFB_OFF_BUCK_STAT) ? bif_buck.flag :
                     (reg_addr == FIFB_OFF_BUCK_MASK) ? bif_buck.mask :
                     (reg_addr == FIFB_OFF_BUCK_SENSE) ? buck_sense_w :
                     (reg_addr == FIFB_OFF_MISC_STAT) ? bif_misc.flag :
                     (reg_addr == FIFB_OFF_MISC_MASK) ? bif_misc.mask :
                     (reg_addr == FIFB_OFF_MISC_SENSE) ? misc_sense_w :
                     (reg_addr == FIFB_OFF_LIN_STAT) ? bif_lin.flag :
                     (reg_addr == FIFB_OFF_LIN_MASK) ? bif_lin.mask :
                     (reg_addr == FIFB_OFF_LIN_SENSE) ? lin_sense_w : FIFB_ZERO;
   // Read data holds its last value between reads
   assign rdata_d = reg_rd_en ? rd_mux_w : rdata_q;
   assign any_pend_w = bif_buck.pend | bif_misc.pend | bif_lin.pend;

   // ----------------------------------------
   // Banks
   // ----------------------------------------
   fifb_flag_bank #(
      .FLAG_BITS(FIFB_BUCK_FLAG_BITS),
      .MASK_BITS(FIFB_BUCK_MASK_BITS),
      .MASK_RST(FIFB_BUCK_MASK_RST)
   ) u_buck (
      .clk_sys(clk_sys),
      .reset(reset),
      .bif(bif_buck)
   );

   fifb_flag_bank #(
      .FLAG_BITS(FIFB_MISC_FLAG_BITS),
      .MASK_BITS(FIFB_MISC_MASK_BITS),
      .MASK_RST(FIFB_MISC_MASK_RST)
   ) u_misc (
      .clk_sys(clk_sys),
      .reset(reset),
      .bif(bif_misc)
   );

   fifb_flag_bank #(
      .FLAG_BITS(FIFB_LIN_FLAG_BITS),
      .MASK_BITS(FIFB_LIN_MASK_BITS),
      .MASK_RST(FIFB_LIN_MASK_RST)
   ) u_lin (
      .clk_sys(clk_sys),
      .reset(reset),
      .bif(bif_lin)
   );

   // ----------------------------------------
   // Start-up phase
   // ----------------------------------------
   // One boot cycle, then run forever until the next reset
   always_comb begin
      case (phase_q)
         FIFB_BOOT: phase_d = FIFB_RUN;
         FIFB_RUN: phase_d = FIFB_RUN;
         default: phase_d = FIFB_BOOT;
      endcase
   end

   // ----------------------------------------
   // Previous-state registers
   // ----------------------------------------
   // Cleared at reset so a condition already present counts as an event
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         buck_prev_q <= 4'h0;
         boost_prev_q <= 1'h0;
         supply_prev_q <= 1'h0;
         blow_prev_q <= 1'h0;
         fuse_prev_q <= 1'h0;
         lin_prev_q <= 6'h00;
      end else begin
         buck_prev_q <= buck_oc_live;
         boost_prev_q <= boost_oc_live;
         supply_prev_q <= supply_ov_live;
         blow_prev_q <= auto_blow_running;
         fuse_prev_q <= fuse_error_live;
         lin_prev_q <= linear_oc_live;
      end
   end

   // ----------------------------------------
   // Output and phase registers
   // ----------------------------------------
   // Interrupt is registered, so it lags the flag by one cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         phase_q <= FIFB_BOOT;
         rdata_q <= FIFB_ZERO;
         irq_n_q <= 1'b1;
      end else begin
         phase_q <= phase_d;
         rdata_q <= rdata_d;
         irq_n_q <= ~any_pend_w;
      end
   end

   assign reg_rdata = rdata_q;
   assign irq_out_n = irq_n_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_irq_follows_pend: assert property (
      @(posedge clk_sys) disable iff (reset)
      ##1 (irq_out_n == !$past(any_pend_w)))
      else $error("Interrupt output does not follow pending flags");

   a_strap_sets_ov: assert property (
      @(posedge clk_sys) disable iff (reset)
      strap_set_w |=> bif_misc.flag[FIFB_BIT_SUPPLY_OV] && phase_q == FIFB_RUN)
      else $error("Grounded front supply did not set overvoltage flag");

   a_blow_done_sets: assert property (
      @(posedge clk_sys) disable iff (reset)
      (blow_prev_q && !auto_blow_running) |=> bif_misc.flag[FIFB_BIT_BLOW])
      else $error("Auto-blow completion not flagged");

   a_misc_sense_live: assert property (
      @(posedge clk_sys) disable iff (reset)
      (reg_rd_en && reg_addr == FIFB_OFF_MISC_SENSE) |=>
         (reg_rdata[FIFB_BIT_BLOW] == $past(auto_blow_running))
         && (reg_rdata[FIFB_BIT_SUPPLY_OV] == $past(supply_ov_live))
         && (reg_rdata[FIFB_BIT_FUSE_ERR] == $past(fuse_error_live)))
      else $error("Misc sense read does not show live state");

   a_buck_sense_map: assert property (
      @(posedge clk_sys) disable iff (reset)
      (reg_rd_en && reg_addr == FIFB_OFF_BUCK_SENSE) |=>
         (reg_rdata[FIFB_SNS_BUCK1B] == $past(buck_oc_live[1])) && !reg_rdata[1])
      else $error("Buck sense bits misplaced");

   // A clear written in the cycle after the set may legally drop the flag
   a_lin_event_flag: assert property (
      @(posedge clk_sys) disable iff (reset)
      (linear_oc_live[0] && !lin_prev_q[0]) |=>
         bif_lin.flag[0] ##1 (bif_lin.flag[0] || $past(bif_lin.wr_stat && bif_lin.wdata[0])))
      else $error("Linear regulator flag not latched");

   // Each event path lands in its flag one edge later, whatever the host writes
   a_buck_event_set: assert property (
      @(posedge clk_sys) disable iff (reset)
      (buck_oc_live[3] && !buck_prev_q[3]) |=> bif_buck.flag[FIFB_FLG_BUCK3])
      else $error("Buck overcurrent flag not latched");

   a_boost_event_set: assert property (
      @(posedge clk_sys) disable iff (reset)
      (boost_oc_live && !boost_prev_q) |=> bif_misc.flag[FIFB_BIT_BOOST])
      else $error("Boost overcurrent flag not latched");

   a_supply_event_set: assert property (
      @(posedge clk_sys) disable iff (reset)
      (supply_ov_live && !supply_prev_q) |=> bif_misc.flag[FIFB_BIT_SUPPLY_OV])
      else $error("Supply overvoltage flag not latched");

   a_fuse_event_set: assert property (
      @(posedge clk_sys) disable iff (reset)
      (fuse_error_live && !fuse_prev_q) |=> bif_misc.flag[FIFB_BIT_FUSE_ERR])
      else $error("Fuse error flag not latched");

   // Sense reads carry no storage of their own, so they must match the inputs
   a_lin_sense_live: assert property (
      @(posedge clk_sys) disable iff (reset)
      (reg_rd_en && reg_addr == FIFB_OFF_LIN_SENSE) |=>
         (reg_rdata == {2'h0, $past(linear_oc_live)}))
      else $error("Linear sense read does not show live state");

   a_boost_sense_live: assert property (
      @(posedge clk_sys) disable iff (reset)
      (reg_rd_en && reg_addr == FIFB_OFF_MISC_SENSE) |=>
         (reg_rdata[FIFB_BIT_BOOST] == $past(boost_oc_live))
         && ((reg_rdata & ~FIFB_MISC_FLAG_BITS) == FIFB_ZERO))
      else $error("Boost sense bit or unused misc sense bit wrong");

endmodule

// >>> bench/fifb_host_model.sv
// Host processor model that drives the register port of the flag banks
module fifb_host_model (
   input wire logic clk_sys, // System clock
   output logic [7:0] reg_addr, // Register address
   output logic reg_wr_en, // Write strobe
   output logic reg_rd_en, // Read strobe
   output logic [7:0] reg_wdata, // Write data
   input wire logic [7:0] reg_rdata // Read data
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Idle levels at time zero
   // ----------------------------------------
   initial begin
      reg_addr = 8'h00;
      reg_wr_en = 1'h0;
      reg_rd_en = 1'h0;
      reg_wdata = 8'h00;
   end

   // ----------------------------------------
   // Accesses: start just after a falling edge, end at one
   // ----------------------------------------
   // Released lines take the inverse value, so a stale one never looks valid.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'h1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      reg_wr_en = 1'h0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // Read data is taken half a cycle after the edge that answers
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd_en = 1'h1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      reg_rd_en = 1'h0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule

// >>> bench/test_fault_interrupt_flag_banks.sv
// Self-checking testbench of the fault interrupt flag banks
module test_fault_interrupt_flag_banks
   import fifb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Pins and expected state
   // ----------------------------------------
   logic clk_sys = 1'h0; // System clock
   logic reset = 1'h1; // Reset, active high
   logic [7:0] reg_addr, reg_wdata, reg_rdata; // Register port
   logic reg_wr_en, reg_rd_en, irq_out_n; // Strobes and interrupt
   logic [13:0] live = 14'h0000; // Buck, boost, supply, blow, fuse, linear
   logic strap = 1'h0; // Front supply grounded
   logic [7:0] fb, fm, fl, mb, mm, ml; // Expected flags and masks
   logic [31:0] seed = 32'h0000E664; // Xorshift state
   int err_total = 0;
   int n_checks = 0;
   logic [7:0] tbl [10] = '{FIFB_OFF_BUCK_STAT, FIFB_OFF_BUCK_MASK, FIFB_OFF_BUCK_SENSE,
      FIFB_OFF_MISC_STAT, FIFB_OFF_MISC_MASK, FIFB_OFF_MISC_SENSE, FIFB_OFF_LIN_STAT,
      FIFB_OFF_LIN_MASK, FIFB_OFF_LIN_SENSE, 8'h20}; // Every register plus a hole

   always #5 clk_sys = ~clk_sys;

   fifb_fault_irq dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .buck_oc_live(live[3:0]), .boost_oc_live(live[4]),
      .supply_ov_live(live[5]), .front_supply_grounded(strap),
      .auto_blow_running(live[6]), .fuse_error_live(live[7]),
      .linear_oc_live(live[13:8]), .irq_out_n(irq_out_n));

   fifb_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected read value; sense bits come straight from the live inputs
   function automatic logic [7:0] exp_reg(input logic [7:0] a);
      case (a)
         FIFB_OFF_BUCK_STAT: return fb;
         FIFB_OFF_BUCK_MASK: return mb;
         FIFB_OFF_BUCK_SENSE: return {3'h0, live[3:1], 1'h0, live[0]};
         FIFB_OFF_MISC_STAT: return fm;
         FIFB_OFF_MISC_MASK: return mm;
         FIFB_OFF_MISC_SENSE: return {live[7:6], 3'h0, live[5], 1'h0, live[4]};
         FIFB_OFF_LIN_STAT: return fl;
         FIFB_OFF_LIN_MASK: return ml;
         FIFB_OFF_LIN_SENSE: return {2'h0, live[13:8]};
         default: return 8'h00;
      endcase
   endfunction

   // Interrupt pin level expected from the modelled flags and masks
   function automatic logic [7:0] exp_irq();
      return {7'h00, ~|((fb & ~mb) | (fm & ~mm) | (fl & ~ml))};
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (err_total == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Reset with live faults quiet; the strap decides the overvoltage flag
   task automatic do_reset(input logic s);
      @(negedge clk_sys);
      reset = 1'h1;
      live = 14'h0000;
      strap = s;
      repeat (8) @(negedge clk_sys);
      check("irq_out_n in reset", {7'h00, irq_out_n}, 8'h01);
      reset = 1'h0;
      fb = 8'h00;
      fm = {5'h00, s, 2'h0};
      fl = 8'h00;
      mb = 8'h7F;
      mm = 8'hC5;
      ml = 8'h3F;
   endtask

   // Read every register back, then the interrupt pin
   task automatic verify();
      logic [7:0] d;
      foreach (tbl[i]) begin
         @(negedge clk_sys);
         host.rd(tbl[i], d);
         check($sformatf("register %h", tbl[i]), d, exp_reg(tbl[i]));
      end
      check("irq_out_n", {7'h00, irq_out_n}, exp_irq());
   endtask

   // New live levels and one write in the same cycle; events win over the clear
   task automatic step(input logic [13:0] nv, input logic [7:0] a, input logic [7:0] wd);
      case (a)
         FIFB_OFF_BUCK_STAT: fb = fb & ~wd;
         FIFB_OFF_MISC_STAT: fm = fm & ~wd;
         FIFB_OFF_LIN_STAT: fl = fl & ~wd;
         FIFB_OFF_BUCK_MASK: mb = wd & 8'h7F;
         FIFB_OFF_MISC_MASK: mm = wd & 8'hC5;
         FIFB_OFF_LIN_MASK: ml = wd & 8'h3F;
         default: ;
      endcase
      fb = fb | {3'h0, nv[3:2] & ~live[3:2], 1'h0, nv[1:0] & ~live[1:0]};
      fm = fm | {nv[7] & ~live[7], live[6] & ~nv[6], 3'h0, nv[5] & ~live[5], 1'h0,
         nv[4] & ~live[4]};
      fl = fl | {2'h0, nv[13:8] & ~live[13:8]};
      @(negedge clk_sys);
      live = nv;
      host.wr(a, wd);
      verify();
   endtask

   // ----------------------------------------
   // Main sequence, once with the strap set and once clear
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      for (int p = 0; p < 2; p++) begin
         do_reset(p == 0);
         verify();
         step(14'h0000, FIFB_OFF_MISC_STAT, 8'h00);
         step(14'h3FFF, FIFB_OFF_MISC_STAT, 8'hFF);
         step(14'h0000, FIFB_OFF_MISC_STAT, 8'hFF);
         step(14'h0000, FIFB_OFF_MISC_MASK, 8'h00);
         repeat (150) begin
            r = xs();
            step(r[13:0], tbl[r[19:16] % 10], r[31:24]);
         end
      end
      end_of_test();
   end

   // Guard against a hang
   initial begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      end_of_test();
   end
endmodule
